// ===== hdl/mhsp_pkg.sv
// constants, types and helper functions of the metering host serial port
// Operation
// - startup samples select line, low SPI, high UART
// - interface type locked two clocks after start
// - after lock select line is chip select only
// - frame returns previous row, each byte MSB first at reset, row zero
// - read address all ones advances pointer
// - write address all ones means no write
// - check byte on at reset, config bit
// - write at frame end, read loads pointer only
// - third byte data low, fourth byte high
// - 70 read rows, 21 writable as halves
// - check polynomial in bits 7:0, reset 0x07
// - sync pulses: latch, measurement reset, global reset
// - results copied into holding flops on latch
// - one self-clearing software latch bit per channel
// - auto-latch bit latches every 128 us
// - soft restore resets config, keeps data, self-clears
// - link uses clock polarity one, phase one
// - config bit 15 selects bit order, reset zero
package mhsp_pkg;
	// ==========================================================
	// clocking and timing
	localparam int CLK_MHZ       = 250;
	localparam int LOCK_CLKS     = 2;
	localparam int SYNC_GAP_NS   = 1000;
	localparam int SYNC_GAP_CYC  = (SYNC_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int AUTO_LATCH_NS = 128000;
	localparam int AUTO_LATCH_CYC = (AUTO_LATCH_NS * CLK_MHZ) / 1000;
	// ==========================================================
	// memory map
	localparam int READ_ROWS   = 70;
	localparam int WRITE_ROWS  = 21;
	localparam int WRITE_CODES = 2 * WRITE_ROWS;
	localparam int DATA_ROWS   = READ_ROWS - WRITE_ROWS;
	localparam int CH1_ROWS    = 24;
	localparam logic [6:0] LAST_ROW   = 7'(READ_ROWS - 1);
	localparam logic [7:0] DUMMY_ADDR = 8'hff;
	localparam logic [7:0] SPC_WADDR  = 8'h24;
	localparam int ROW_SPC = 18;
	localparam int ROW_PCT = 2;
	localparam int PCT_LATCH1 = 0;
	localparam int PCT_LATCH2 = 1;
	localparam int PCT_AUTO   = 2;
	localparam int PCT_SOFT   = 3;
	localparam int BIT_ORDER_POS = 15;
	localparam int CHECK_ON_POS  = 14;
	localparam int POLY_LSB      = 0;
	localparam logic [31:0] SPC_RESET  = 32'h0000_4007;
	localparam logic [2:0] LAST_BYTE_CHK   = 3'h4;
	localparam logic [2:0] LAST_BYTE_PLAIN = 3'h3;
	// pin slots in the synchroniser vectors
	localparam int PIN_EN  = 4;
	localparam int PIN_SEL = 3;
	localparam int PIN_SCK = 2;
	localparam int PIN_DI  = 1;
	localparam int PIN_PLS = 0;
	typedef enum logic [1:0] {MODE_WAIT, MODE_SPI, MODE_UART} mhsp_mode_e;
	// ==========================================================
	// helpers
	function automatic logic [7:0] mhsp_crc8(input logic [7:0] c, input logic [7:0] d,
		input logic [7:0] p);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ p) : (r << 1);
		end
		return r;
	endfunction
	function automatic logic [7:0] mhsp_rev8(input logic [7:0] d);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = d[7 - i];
		end
		return r;
	endfunction
endpackage

// ===== hdl/mhsp_fifo_if.sv
// handshake carrier between the frame collector and its frame fifo
`timescale 1ns/1ps
interface mhsp_fifo_if #(parameter int W = 32);
	logic [W-1:0] in_data;
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] out_data;
	logic         out_valid;
	logic         out_ready;
	modport fill  (output in_data, output in_valid, input in_ready);
	modport store (input in_data, input in_valid, output in_ready,
		output out_data, output out_valid, input out_ready);
	modport drain (input out_data, input out_valid, output out_ready);
endinterface

// ===== hdl/mhsp_fifo.sv
// frame fifo with valid/ready on both sides
`timescale 1ns/1ps
module mhsp_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,    // core clock
	input wire logic resetn, // async reset, active low
	mhsp_fifo_if.store f     // fill and drain sides
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} mhsp_fifo_s;
	mhsp_fifo_s st_r;
	mhsp_fifo_s st_nxt;
	logic push;
	logic pop;
	generate
		if (DEPTH < 2 || W < 1) begin : g_bad
			$error("fifo depth must be at least two");
		end
	endgenerate
	// ==========================================================
	// flags come straight from the count, so full and empty are exact
	assign f.in_ready  = (st_r.cnt != (AW + 1)'(DEPTH));
	assign f.out_valid = (st_r.cnt != '0);
	assign f.out_data  = st_r.mem[st_r.rp];
	assign push = f.in_valid && f.in_ready;
	assign pop  = f.out_valid && f.out_ready;
	// pointer and count update
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp] = f.in_data;
			st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
		end
		st_nxt.cnt = st_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// ===== hdl/mhsp_top.sv
// host serial port: mode pick, spi frame engine, row memory, latch and resets
`timescale 1ns/1ps
module mhsp_top #(
	parameter int unsigned AUTO_LATCH_CYCLES = mhsp_pkg::AUTO_LATCH_CYC,
	parameter int unsigned FIFO_DEPTH        = 16
) (
	input  wire logic        clk,            // core clock, 250 MHz
	input  wire logic        resetn,         // async reset, active low
	input  wire logic        en_pin,         // chip enable pin
	input  wire logic        select_line,    // mode strap, then chip select
	input  wire logic        sclk,           // link clock pin
	input  wire logic        mosi,           // serial data in
	input  wire logic        sync_pulse_pin, // latch and reset pulses
	input  wire logic        res_we,         // result row update strobe
	input  wire logic [5:0]  res_row,        // result row index
	input  wire logic [31:0] res_data,       // result row value
	output logic             miso,           // serial data out
	output logic             miso_oe_n,      // low while driving miso
	output logic             spi_locked,     // interface locked as spi
	output logic             uart_selected,  // interface locked as uart
	output logic             latch_pulse,    // pulse: holding flops loaded
	output logic             meas_reset,     // pulse: measurement reset
	output logic             glob_reset      // pulse: global reset
);
	import mhsp_pkg::*;
	typedef struct packed {
		logic [4:0]  s1;
		logic [4:0]  s2;
		logic        p_sel;
		logic        p_sck;
		logic        p_pls;
		mhsp_mode_e  mode;
		logic [1:0]  lock_cnt;
		logic [2:0]  bit_cnt;
		logic [2:0]  byte_cnt;
		logic [7:0]  rx_sh;
		logic [7:0]  crc_rx;
		logic [7:0]  crc_tx;
		logic [31:0] rx_word;
		logic [31:0] tx_word;
		logic        pend;
		logic [31:0] pend_word;
		logic [6:0]  rptr;
		logic [1:0]  pls_cnt;
		logic [15:0] pls_tmr;
		logic [31:0] auto_tmr;
		logic        miso;
		logic        miso_oe_n;
		logic        spi_o;
		logic        uart_o;
		logic        latch_p;
		logic        meas_p;
		logic        glob_p;
		logic [WRITE_ROWS-1:0][31:0] cfg;
		logic [DATA_ROWS-1:0][31:0]  hold;
		logic [DATA_ROWS-1:0][31:0]  live;
	} mhsp_st_s;
	localparam logic [15:0] SYNC_GAP = 16'(SYNC_GAP_CYC);
	mhsp_st_s st_r;
	mhsp_st_s st_nxt;
	mhsp_fifo_if #(.W(32)) fif ();
	logic sel_s, sck_s, di_s, pls_s, en_s;
	logic pop, stall, act_l1, act_l2, act_meas, act_glob;
	logic flip, chk_on, ok, last;
	logic [7:0] rxb, tb, poly, r_addr, w_addr;
	logic [15:0] w_data;
	logic [31:0] ld;
	logic [2:0]  bi;
	generate
		if (AUTO_LATCH_CYCLES < 2 || FIFO_DEPTH < 2) begin : g_bad
			$error("auto latch period and fifo depth must be at least two");
		end
	endgenerate
	// ==========================================================
	// helpers
	function automatic logic [WRITE_ROWS-1:0][31:0] cfg_default();
		logic [WRITE_ROWS-1:0][31:0] c;
		c = '0;
		c[ROW_SPC] = SPC_RESET;
		return c;
	endfunction
	function automatic logic [7:0] tx_byte(input logic [31:0] w, input logic [7:0] c,
		input logic [2:0] k);
		return (k < 3'h4) ? w[8 * k +: 8] : c;
	endfunction
	// ==========================================================
	// synchronised pins and frame fifo
	assign en_s  = st_r.s2[PIN_EN];
	assign sel_s = st_r.s2[PIN_SEL];
	assign sck_s = st_r.s2[PIN_SCK];
	assign di_s  = st_r.s2[PIN_DI];
	assign pls_s = st_r.s2[PIN_PLS];
	assign flip   = st_r.cfg[ROW_SPC][BIT_ORDER_POS];
	assign chk_on = st_r.cfg[ROW_SPC][CHECK_ON_POS];
	assign poly   = st_r.cfg[ROW_SPC][POLY_LSB +: 8];
	assign fif.in_valid  = st_r.pend;
	assign fif.in_data   = st_r.pend_word;
	assign fif.out_ready = !stall;
	assign pop    = fif.out_valid && !stall;
	assign r_addr = fif.out_data[7:0];
	assign w_addr = fif.out_data[15:8];
	assign w_data = fif.out_data[31:16];
	mhsp_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk    (clk),
		.resetn (resetn),
		.f      (fif)
	);
	// ==========================================================
	// next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = {en_pin, select_line, sclk, mosi, sync_pulse_pin};
		st_nxt.s2 = st_r.s1;
		st_nxt.p_sel = sel_s;
		st_nxt.p_sck = sck_s;
		st_nxt.p_pls = pls_s;
		st_nxt.latch_p = 1'b0;
		st_nxt.meas_p = 1'b0;
		st_nxt.glob_p = 1'b0;
		act_l1 = 1'b0;
		act_l2 = 1'b0;
		act_meas = 1'b0;
		act_glob = 1'b0;
		rxb = '0;
		tb = '0;
		ok = 1'b0;
		last = 1'b0;
		ld = '0;
		bi = '0;
		// mode pick two clocks after enable, then frozen until enable drops
		if (!en_s) begin
			st_nxt.mode = MODE_WAIT;
			st_nxt.lock_cnt = '0;
		end else begin
			case (st_r.mode)
				MODE_WAIT: begin
					if (st_r.lock_cnt == 2'(LOCK_CLKS - 1)) begin
						st_nxt.mode = sel_s ? MODE_UART : MODE_SPI;
					end else begin
						st_nxt.lock_cnt = st_r.lock_cnt + 1'b1;
					end
				end
				MODE_SPI, MODE_UART: st_nxt.mode = st_r.mode;
				default: st_nxt.mode = MODE_WAIT;
			endcase
		end
		st_nxt.spi_o = (st_nxt.mode == MODE_SPI);
		st_nxt.uart_o = (st_nxt.mode == MODE_UART);
		// a pending frame leaves as soon as the fifo takes it
		if (st_r.pend && fif.in_ready) begin
			st_nxt.pend = 1'b0;
		end
		// spi engine: drive on the falling edge, sample on the rising edge
		st_nxt.miso_oe_n = !(st_r.mode == MODE_SPI && !sel_s);
		if (st_r.mode != MODE_SPI || sel_s) begin
			st_nxt.bit_cnt = '0;
			st_nxt.byte_cnt = '0;
			st_nxt.crc_rx = '0;
			st_nxt.crc_tx = '0;
		end else if (st_r.p_sck && !sck_s) begin
			ld = st_r.tx_word;
			if (st_r.bit_cnt == '0 && st_r.byte_cnt == '0) begin
				ld = (st_r.rptr < 7'(WRITE_ROWS)) ? st_r.cfg[st_r.rptr]
					: st_r.hold[st_r.rptr - 7'(WRITE_ROWS)];
				st_nxt.tx_word = ld;
			end
			tb = tx_byte(ld, st_r.crc_tx, st_r.byte_cnt);
			bi = flip ? st_r.bit_cnt : 3'h7 - st_r.bit_cnt;
			st_nxt.miso = tb[bi];
		end else if (!st_r.p_sck && sck_s) begin
			st_nxt.rx_sh = {st_r.rx_sh[6:0], di_s};
			st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
			if (st_r.bit_cnt == 3'h7) begin
				rxb = flip ? mhsp_rev8({st_r.rx_sh[6:0], di_s})
					: {st_r.rx_sh[6:0], di_s};
				tb = tx_byte(st_r.tx_word, st_r.crc_tx, st_r.byte_cnt);
				last = st_r.byte_cnt == (chk_on ? LAST_BYTE_CHK : LAST_BYTE_PLAIN);
				if (st_r.byte_cnt < 3'h4) begin
					st_nxt.rx_word[8 * st_r.byte_cnt +: 8] = rxb;
					st_nxt.crc_rx = mhsp_crc8(st_r.crc_rx, rxb, poly);
					st_nxt.crc_tx = mhsp_crc8(st_r.crc_tx, tb, poly);
				end
				ok = !chk_on || (rxb == st_r.crc_rx);
				if (last) begin
					st_nxt.byte_cnt = '0;
					// a frame that finds the previous one still waiting is dropped
					if (!st_r.pend) begin
						st_nxt.pend = 1'b1;
						st_nxt.pend_word = {st_nxt.rx_word[31:16],
							ok ? st_nxt.rx_word[15:8] : DUMMY_ADDR, st_nxt.rx_word[7:0]};
					end
				end else begin
					st_nxt.byte_cnt = st_r.byte_cnt + 1'b1;
				end
			end
		end
		// result rows refreshed by the measurement engine
		if (res_we && res_row < 6'(DATA_ROWS)) begin
			st_nxt.live[res_row] = res_data;
		end
		// sync pulses counted while deselected, acted on after a quiet gap
		if (st_r.mode == MODE_WAIT || !sel_s) begin
			st_nxt.pls_cnt = '0;
			st_nxt.pls_tmr = '0;
		end else if (!st_r.p_pls && pls_s) begin
			st_nxt.pls_cnt = (st_r.pls_cnt == 2'h3) ? 2'h3 : st_r.pls_cnt + 1'b1;
			st_nxt.pls_tmr = '0;
		end else if (st_r.pls_cnt != '0) begin
			st_nxt.pls_tmr = st_r.pls_tmr + 1'b1;
			if (st_r.pls_tmr == SYNC_GAP) begin
				act_l1 = (st_r.pls_cnt == 2'h1);
				act_l2 = (st_r.pls_cnt == 2'h1);
				act_meas = (st_r.pls_cnt == 2'h2);
				act_glob = (st_r.pls_cnt == 2'h3);
				st_nxt.pls_cnt = '0;
			end
		end
		// auto latch once per measurement period
		if (st_r.cfg[ROW_PCT][PCT_AUTO]) begin
			st_nxt.auto_tmr = st_r.auto_tmr + 1'b1;
			if (st_r.auto_tmr == AUTO_LATCH_CYCLES - 1) begin
				st_nxt.auto_tmr = '0;
				act_l1 = 1'b1;
				act_l2 = 1'b1;
			end
		end else begin
			st_nxt.auto_tmr = '0;
		end
		// software latch bits clear themselves once the copy is done
		if (st_r.cfg[ROW_PCT][PCT_LATCH1]) begin
			act_l1 = 1'b1;
			st_nxt.cfg[ROW_PCT][PCT_LATCH1] = 1'b0;
		end
		if (st_r.cfg[ROW_PCT][PCT_LATCH2]) begin
			act_l2 = 1'b1;
			st_nxt.cfg[ROW_PCT][PCT_LATCH2] = 1'b0;
		end
		for (int i = 0; i < DATA_ROWS; i++) begin
			if ((i < CH1_ROWS) ? act_l1 : act_l2) begin
				st_nxt.hold[i] = st_r.live[i];
			end
		end
		st_nxt.latch_p = act_l1 || act_l2;
		// soft restore touches configuration only, data rows stay
		if (st_r.cfg[ROW_PCT][PCT_SOFT]) begin
			st_nxt.cfg = cfg_default();
		end
		if (act_meas || act_glob) begin
			st_nxt.hold = '0;
			st_nxt.live = '0;
			st_nxt.meas_p = 1'b1;
		end
		if (act_glob) begin
			st_nxt.cfg = cfg_default();
			st_nxt.rptr = '0;
			st_nxt.glob_p = 1'b1;
		end
		// frame execution; held off while a latch or reset lands, which is
		// what lets the fifo fill and push back on the frame collector
		stall = act_l1 || act_l2 || act_meas || act_glob
			|| st_r.cfg[ROW_PCT][PCT_SOFT];
		if (fif.out_valid && !stall) begin
			if (r_addr == DUMMY_ADDR) begin
				st_nxt.rptr = (st_r.rptr == LAST_ROW) ? '0 : st_r.rptr + 1'b1;
			end else if (!r_addr[0] && r_addr[7:1] <= LAST_ROW) begin
				st_nxt.rptr = r_addr[7:1];
			end
			if (w_addr != DUMMY_ADDR && w_addr < 8'(WRITE_CODES)) begin
				st_nxt.cfg[w_addr[5:1]][16 * w_addr[0] +: 16] = w_data;
			end
		end
	end
	// ==========================================================
	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.miso <= 1'b1;
			st_r.miso_oe_n <= 1'b1;
			st_r.p_sck <= 1'b1;
			st_r.p_pls <= 1'b1;
			st_r.p_sel <= 1'b1;
			st_r.cfg <= cfg_default();
		end else begin
			st_r <= st_nxt;
		end
	end
	// outputs straight from the state register
	assign miso = st_r.miso;
	assign miso_oe_n = st_r.miso_oe_n;
	assign spi_locked = st_r.spi_o;
	assign uart_selected = st_r.uart_o;
	assign latch_pulse = st_r.latch_p;
	assign meas_reset = st_r.meas_p;
	assign glob_reset = st_r.glob_p;
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	property p_lock_time;
		($rose(en_s) ##1 en_s) |=> (st_r.mode != MODE_WAIT);
	endproperty
	a_lock_time: assert property (p_lock_time) else $error("mode not locked");
	property p_lock_hold;
		(st_r.mode != MODE_WAIT && en_s) |=> (st_r.mode == $past(st_r.mode));
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("mode changed");
	property p_uart_pick;
		(st_r.mode == MODE_WAIT ##1 st_r.mode != MODE_WAIT)
			|-> ((st_r.mode == MODE_UART) == $past(sel_s));
	endproperty
	a_uart_pick: assert property (p_uart_pick) else $error("wrong mode pick");
	property p_soft;
		st_r.cfg[ROW_PCT][PCT_SOFT] |=> (st_r.cfg[ROW_SPC] == SPC_RESET)
			&& !st_r.cfg[ROW_PCT][PCT_SOFT];
	endproperty
	a_soft: assert property (p_soft) else $error("soft restore failed");
	property p_swlatch;
		st_r.cfg[ROW_PCT][PCT_LATCH1] |=> latch_pulse && !st_r.cfg[ROW_PCT][PCT_LATCH1];
	endproperty
	a_swlatch: assert property (p_swlatch) else $error("latch bit stuck");
	property p_glob_poly;
		glob_reset |-> (st_r.cfg[ROW_SPC][7:0] == SPC_RESET[7:0]) && meas_reset;
	endproperty
	a_glob_poly: assert property (p_glob_poly) else $error("poly not restored");
	property p_no_write;
		(pop && w_addr == DUMMY_ADDR) |=> $stable(st_r.cfg);
	endproperty
	a_no_write: assert property (p_no_write) else $error("dummy write landed");
	property p_write;
		(pop && w_addr == SPC_WADDR) |=> (st_r.cfg[ROW_SPC][15:0] == $past(w_data));
	endproperty
	a_write: assert property (p_write) else $error("write lost");
	property p_rptr_step;
		(pop && r_addr == DUMMY_ADDR && st_r.rptr != LAST_ROW)
			|=> (st_r.rptr == $past(st_r.rptr) + 7'h01);
	endproperty
	a_rptr_step: assert property (p_rptr_step) else $error("pointer not stepped");
	property p_release;
		(sel_s ##1 sel_s) |-> miso_oe_n;
	endproperty
	a_release: assert property (p_release) else $error("miso driven");
	c_frame: cover property (st_r.pend && fif.in_ready);
	c_uart: cover property (uart_selected);
	c_glob: cover property (glob_reset);
	c_full: cover property (!fif.in_ready);
endmodule

// ===== verif/mhsp_host_model.sv
// host microcontroller model: a mode 3 link master for the serial port
`timescale 1ns/1ps
module mhsp_host_model (
	input  wire logic clk,         // core clock, paces link edges
	input  wire logic miso,        // serial data from the device
	output logic      select_line, // strap level, then chip select
	output logic      sclk,        // link clock, idles high
	output logic      mosi         // serial data to the device
);
	realtime t_next;
	// strap starts low at time zero; the bench moves it with set_sel before each pick
	initial begin
		select_line = 1'b0;
		sclk        = 1'b1;
		mosi        = 1'b0;
		t_next      = 0.0;
	end
	// half of a 125 ns period on core edges; rounding is paid back next half
	task automatic half();
		t_next = t_next + 62.5;
		while ($realtime < t_next) @(posedge clk);
	endtask
	// move the select line between frames
	task automatic set_sel(input logic v);
		@(posedge clk);
		select_line <= v;
	endtask
	// one whole frame of nb bytes, byte 0 first, bit order set by lsb
	task automatic xfer(input logic [39:0] tx, input int nb, input logic lsb,
		output logic [39:0] rx);
		int b;
		rx = '0;
		@(posedge clk);
		select_line <= 1'b0;
		t_next = $realtime;
		half();
		for (int k = 0; k < nb; k++) begin
			for (int i = 0; i < 8; i++) begin
				b = 8 * k + (lsb ? i : 7 - i);
				half();
				sclk <= 1'b0; // data moves on the leading fall
				mosi <= tx[b];
				half();
				rx[b] = miso; // taken on the trailing rise
				sclk <= 1'b1;
			end
		end
		half();
		select_line <= 1'b1;
		mosi        <= ~mosi; // released: inverse of last bit, never a stale copy
		half();
	endtask
endmodule

// ===== verif/tb_mhsp_top.sv
// self-checking bench: mode pick, frames, pointer, check byte, latches, resets
`timescale 1ns/1ps
module tb_mhsp_top;
	import mhsp_pkg::*;
	localparam logic [7:0] POLY = 8'h07; // check polynomial after reset
	logic        clk            = 1'b0;
	logic        resetn         = 1'b0;
	logic        en_pin         = 1'b0;
	logic        sync_pulse_pin = 1'b1;
	logic        res_we         = 1'b0;
	logic [5:0]  res_row        = 6'h00;
	logic [31:0] res_data       = 32'h0;
	logic        select_line;
	logic        sclk;
	logic        mosi;
	logic        miso;
	logic        miso_oe_n;
	logic        spi_locked;
	logic        uart_selected;
	logic        latch_pulse;
	logic        meas_reset;
	logic        glob_reset;
	logic        crc_on = 1'b1;
	logic        lsb    = 1'b0;
	int          n_errors    = 0;
	int          checks_done = 0;
	int          n_lat  = 0;
	int          n_meas = 0;
	int          n_glob = 0;
	int          n_drv  = 0;
	// ==========================================================
	// clock, device and host
	always #2 clk = ~clk;
	mhsp_top #(.AUTO_LATCH_CYCLES(16), .FIFO_DEPTH(16)) u_mhsp_top (
		.clk(clk), .resetn(resetn), .en_pin(en_pin), .select_line(select_line),
		.sclk(sclk), .mosi(mosi), .sync_pulse_pin(sync_pulse_pin), .res_we(res_we),
		.res_row(res_row), .res_data(res_data), .miso(miso), .miso_oe_n(miso_oe_n),
		.spi_locked(spi_locked), .uart_selected(uart_selected), .latch_pulse(latch_pulse),
		.meas_reset(meas_reset), .glob_reset(glob_reset));
	mhsp_host_model u_mhsp_host_model (
		.clk(clk), .miso(miso), .select_line(select_line), .sclk(sclk), .mosi(mosi));
	// count the one-cycle pulses; the old value is read, so no race
	always @(posedge clk) begin
		n_lat  = n_lat + (latch_pulse === 1'b1);
		n_meas = n_meas + (meas_reset === 1'b1);
		n_glob = n_glob + (glob_reset === 1'b1);
		n_drv  = n_drv + (miso_oe_n === 1'b0);
	end
	// ==========================================================
	// helpers
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// bitwise crc-8 over four bytes, byte 0 first, each byte msb first
	function automatic logic [7:0] crc4(input logic [31:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int n = 0; n < 32; n++) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[8 * (n / 8) + 7 - n % 8]) ? POLY : 8'h00);
		end
		return c;
	endfunction
	// one frame; bad spoils the check byte sent
	task automatic frame(input logic [7:0] ra, input logic [7:0] wa, input logic [15:0] wd,
		input logic [31:0] exp, input logic bad);
		logic [39:0] tx;
		logic [39:0] rx;
		tx = {8'h00, wd[15:8], wd[7:0], wa, ra};
		tx[39:32] = crc4(tx[31:0]) ^ {7'h00, bad};
		u_mhsp_host_model.xfer(tx, crc_on ? 5 : 4, lsb, rx);
		chk("read row", exp, rx[31:0]);
		if (crc_on) chk("reply check byte", {24'h0, crc4(exp)}, {24'h0, rx[39:32]});
	endtask
	task automatic res(input logic [5:0] r, input logic [31:0] d);
		@(posedge clk);
		res_we   <= 1'b1;
		res_row  <= r;
		res_data <= d;
		@(posedge clk);
		res_we <= 1'b0;
	endtask
	// n sync pulses, then past the fixed quiet gap, then pulse counts
	task automatic sync(input int n, input int el, input int em, input int eg);
		n_lat  = 0;
		n_meas = 0;
		n_glob = 0;
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge clk);
			sync_pulse_pin <= 1'b0;
			repeat (8) @(posedge clk);
			sync_pulse_pin <= 1'b1;
		end
		repeat (300) @(posedge clk);
		chk("latch pulses", el, n_lat);
		chk("measurement resets", em, n_meas);
		chk("global resets", eg, n_glob);
	endtask
	task automatic wait_mode(input logic uart);
		int i;
		for (i = 0; i < 20 && (uart ? uart_selected : spi_locked) !== 1'b1; i++) begin
			@(posedge clk);
		end
		if (i == 20) begin
			n_errors++;
			summarize();
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk("miso_oe_n", 32'h1, 32'(miso_oe_n));
		chk("spi_locked", 32'h0, 32'(spi_locked));
		u_mhsp_host_model.set_sel(1'b1);
		repeat (4) @(posedge clk);
		en_pin <= 1'b1;
		wait_mode(1'b1);
		chk("spi_locked", 32'h0, 32'(spi_locked));
		en_pin <= 1'b0;
		u_mhsp_host_model.set_sel(1'b0);
		repeat (4) @(posedge clk);
		en_pin <= 1'b1;
		wait_mode(1'b0);
		chk("uart_selected", 32'h0, 32'(uart_selected));
		u_mhsp_host_model.set_sel(1'b1);
		sync(3, 0, 1, 1);
		frame(8'h24, 8'hff, 16'h1234, 32'h0, 1'b0);
		chk("miso driven in frame", 32'h1, 32'(n_drv > 0));
		chk("miso_oe_n", 32'h1, 32'(miso_oe_n));
		frame(8'h02, 8'h03, 16'habcd, 32'h0000_4007, 1'b0);
		frame(8'hff, 8'h06, 16'haabb, 32'habcd_0000, 1'b0);
		frame(8'hff, 8'h00, 16'h5a5a, 32'h0, 1'b0);
		frame(8'h8a, 8'h07, 16'h1122, 32'h0000_aabb, 1'b1);
		frame(8'hff, 8'hff, 16'h0000, 32'h0, 1'b0);
		frame(8'h06, 8'hff, 16'h0000, 32'h0000_5a5a, 1'b0);
		frame(8'h24, 8'h24, 16'h8007, 32'h0000_aabb, 1'b0);
		crc_on = 1'b0;
		lsb    = 1'b1;
		frame(8'hff, 8'hff, 16'h0000, 32'h0000_8007, 1'b0);
		res(6'h00, 32'h1234_5678);
		res(6'h1e, 32'h0bad_f00d);
		sync(1, 1, 0, 0);
		frame(8'h2a, 8'hff, 16'h0000, 32'h0, 1'b0);
		frame(8'h66, 8'hff, 16'h0000, 32'h1234_5678, 1'b0);
		frame(8'hff, 8'hff, 16'h0000, 32'h0bad_f00d, 1'b0);
		res(6'h00, 32'hcafe_0001);
		res(6'h1e, 32'h0000_0002);
		frame(8'h2a, 8'h04, 16'h0001, 32'h0, 1'b0);
		frame(8'h66, 8'hff, 16'h0000, 32'hcafe_0001, 1'b0);
		frame(8'h04, 8'hff, 16'h0000, 32'h0bad_f00d, 1'b0);
		frame(8'hff, 8'h04, 16'h0004, 32'h0, 1'b0);
		n_lat = 0;
		repeat (200) @(posedge clk);
		chk("auto latch count", 32'h1, 32'(n_lat >= 11 && n_lat <= 14));
		frame(8'h24, 8'h04, 16'h0008, 32'h0000_aabb, 1'b0);
		crc_on = 1'b1;
		lsb    = 1'b0;
		frame(8'h66, 8'hff, 16'h0000, 32'h0000_4007, 1'b0);
		frame(8'hff, 8'hff, 16'h0000, 32'h0000_0002, 1'b0);
		sync(2, 0, 1, 0);
		frame(8'hff, 8'h24, 16'h0007, 32'h0, 1'b0);
		crc_on = 1'b0;
		sync(3, 0, 1, 1);
		crc_on = 1'b1;
		frame(8'h66, 8'hff, 16'h0000, 32'h0, 1'b0);
		frame(8'hff, 8'hff, 16'h0000, 32'h0, 1'b0);
		chk("spi_locked", 32'h1, 32'(spi_locked));
		chk("uart_selected", 32'h0, 32'(uart_selected));
		summarize();
	end
endmodule
